//--- hw/ccsp_top.v
// serial port of a two channel cascaded codec
// Summary of operation
// R1 - host sends second channel word first
// R2 - rate registers update together, no gaps
// R3 - cascade length resets to zero
// R4 - first register write leaves program mode
// R5 - two adc out, two dac in per sample
// R6 - dac loads just before frame sync
// R7 - dac advance setting moves load earlier
// R8 - sixteen bits shift out after frame sync
// R9 - full dac word goes to holding register
// R10 - both channels raise frame sync together
// R11 - foreign words pass on unchanged
// R12 - nonzero address decremented and forwarded
// R13 - addressed words apply in same cycle
// R14 - second register holds clock and rates
// R15 - third register holds power controls
// R16 - select bit one enters data mode
// R17 - data words counted by frame syncs
// R18 - count match loads dac holding register
// R19 - below count, forward word onward
// R20 - counter clears after each dac update
// R21 - second channel words travel first
// R22 - host preloads word, pairs same register
`timescale 1ns/1ps
`include "ccsp_consts.vh"

module ccsp_top (
  // clock and reset
  input  wire        clock_i,
  input  wire        rst_i,
  // host serial link
  input  wire        serial_data_in_i,
  input  wire        input_frame_sync_i,
  output wire        serial_data_out_o,
  output wire        output_frame_sync_o,
  output wire        sclk_o,
  // converter side, channel 1
  input  wire [15:0] adc_ch1_i,
  output wire [15:0] dac_ch1_o,
  // converter side, channel 2
  input  wire [15:0] adc_ch2_i,
  output wire [15:0] dac_ch2_o,
  // status and power, bit 0 channel 1
  output wire [1:0]  data_mode_o,
  output wire [1:0]  mixed_mode_o,
  output wire [1:0]  adc_pwr_o,
  output wire [1:0]  dac_pwr_o,
  output wire [1:0]  ref_pwr_o,
  output wire [5:0]  casc_len_o,
  output wire [1:0]  divided_master_clock_div_o
);

  // pin synchronisers, three stages each
  reg  [2:0]  sdi_sync;   // serial data in stages
  reg  [2:0]  ifs_sync;   // frame sync in stages
  reg         sdi_val;    // settled serial data in
  reg         ifs_val;    // settled frame sync in

  // shared timing
  wire        tick;       // rising serial clock edge
  wire        sample;     // sampling event on a tick
  wire        dac_load;   // dac converter load strobe
  wire        commit;     // apply staged writes

  // per channel gathered signals
  wire [1:0]  ofs_v;      // output frame syncs
  wire [1:0]  msb_v;      // serial register msbs
  wire [1:0]  pend_v;     // staged write waiting
  wire [1:0]  ch_din;     // serial input per channel
  wire [1:0]  ch_ifs;     // frame sync in per channel
  wire [15:0] crb_flat;   // second registers
  wire [15:0] crd_flat;   // fourth registers
  wire [31:0] adc_flat;   // adc words
  wire [31:0] dac_flat;   // dac words

  // true when a word is a control word, for any channel
  function is_ctrl;
    input [15:0] w;
    begin
      is_ctrl = w[`CCSP_CTRL_BIT];
    end
  endfunction

  // true when a control word addresses this channel
  function is_mine;
    input [15:0] w;
    begin
      is_mine = w[`CCSP_CTRL_BIT] & (w[`CCSP_ADDR_HI:`CCSP_ADDR_LO] == 3'h0);
    end
  endfunction

  // pins pass three flops; change taken when last two agree
  always @(posedge clock_i) begin
    if (rst_i) begin
      sdi_sync <= 3'h0;
      ifs_sync <= 3'h0;
      sdi_val  <= 1'b0;
      ifs_val  <= 1'b0;
    end else begin
      sdi_sync <= {sdi_sync[1:0], serial_data_in_i};
      ifs_sync <= {ifs_sync[1:0], input_frame_sync_i};
      if (sdi_sync[1] == sdi_sync[2]) begin
        sdi_val <= sdi_sync[2];
      end
      if (ifs_sync[1] == ifs_sync[2]) begin
        ifs_val <= ifs_sync[2];
      end
    end
  end

  // clocks follow channel 1 second register, advance from fourth
  ccsp_clkgen u_clkgen (
    .clock_i    (clock_i),
    .rst_i      (rst_i),
    .div_sel_i  (crb_flat[`CCSP_CRB_DIV_HI:`CCSP_CRB_DIV_LO]),
    .sclk_sel_i (crb_flat[`CCSP_CRB_SCK_HI:`CCSP_CRB_SCK_LO]),
    .rate_sel_i (crb_flat[`CCSP_CRB_SR_HI:`CCSP_CRB_SR_LO]),
    .adv_sel_i  (crd_flat[`CCSP_CRD_ADV_HI:`CCSP_CRD_ADV_LO]),
    .sclk_o     (sclk_o),
    .tick_o     (tick),
    .sample_o   (sample),
    .dac_load_o (dac_load)
  );

  // channel 1 faces the host input, channel 2 the host output
  assign ch_din = {msb_v[0], sdi_val};
  assign ch_ifs = {ofs_v[0], ifs_val}; // R10
  assign adc_flat = {adc_ch2_i, adc_ch1_i};
  // staged writes of all channels commit on one tick
  assign commit = tick & (|pend_v); // R13

  // cascade output leaves from channel 2
  assign serial_data_out_o   = msb_v[1]; // R8 R21
  assign output_frame_sync_o = ofs_v[1];
  assign dac_ch1_o = dac_flat[15:0];
  assign dac_ch2_o = dac_flat[31:16];

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_ch
      reg  [15:0] sreg;     // serial shift register
      reg         ofs;      // output frame sync
      reg  [4:0]  tx_left;  // bits still to send
      reg  [4:0]  rx_left;  // bits still to receive
      reg  [2:0]  fs_cnt;   // frame syncs counted in data mode
      reg  [7:0]  cra;      // mode and cascade length
      reg  [7:0]  crb;      // clock divider and rates
      reg  [7:0]  crc;      // power controls
      reg  [7:0]  crd;      // dac advance
      reg         pend;     // write staged
      reg  [2:0]  pend_reg; // staged register select
      reg  [7:0]  pend_dat; // staged register data
      reg  [15:0] dac_hold; // dac holding register
      reg  [15:0] dac_out;  // value on the converter
      wire [15:0] word;     // word complete this tick
      wire        dmode;    // data mode
      wire        mmode;    // mixed mode
      wire [2:0]  casc;     // cascade length field

      assign word  = {sreg[14:0], ch_din[i]};
      assign dmode = cra[`CCSP_CRA_DATA];
      assign mmode = cra[`CCSP_CRA_MIXED];
      assign casc  = cra[`CCSP_CRA_CASC_HI:`CCSP_CRA_CASC_LO];

      // gather for the cascade and the ports
      assign ofs_v[i]  = ofs;
      assign msb_v[i]  = sreg[15];
      assign pend_v[i] = pend;
      assign crb_flat[i*8 +: 8] = crb;
      assign crd_flat[i*8 +: 8] = crd;
      assign dac_flat[i*16 +: 16] = dac_out;
      assign data_mode_o[i]  = dmode;
      assign mixed_mode_o[i] = mmode;
      assign adc_pwr_o[i] = crc[`CCSP_CRC_ADC_PWR]; // R15
      assign dac_pwr_o[i] = crc[`CCSP_CRC_DAC_PWR]; // R15
      assign ref_pwr_o[i] = crc[`CCSP_CRC_REF_PWR]; // R15
      assign casc_len_o[i*3 +: 3] = casc;
      assign divided_master_clock_div_o[i] = |crb[`CCSP_CRB_DIV_HI:`CCSP_CRB_DIV_LO];

      // register writes, staged and committed together
      always @(posedge clock_i) begin
        if (rst_i) begin
          cra      <= `CCSP_CRA_RESET; // R3
          crb      <= `CCSP_CRB_RESET;
          crc      <= `CCSP_CRC_RESET;
          crd      <= `CCSP_CRD_RESET;
        end else if (commit && pend) begin
          // every channel holding a write applies it now
          case (pend_reg)
            `CCSP_REG_CRA: begin
              cra <= pend_dat; // R4 R16
            end
            `CCSP_REG_CRB: begin
              crb <= pend_dat; // R2 R14
            end
            `CCSP_REG_CRC: begin
              crc <= pend_dat; // R15
            end
            `CCSP_REG_CRD: begin
              crd <= pend_dat; // R7
            end
            default: begin
              // unused selects are ignored
              cra <= cra;
            end
          endcase
        end
      end

      // dac converter takes the holding register at the strobe
      always @(posedge clock_i) begin
        if (rst_i) begin
          dac_out <= 16'h0000;
        end else if (dac_load) begin
          dac_out <= dac_hold; // R6 R7
        end
      end

      // serial path: shifting, word handling, frame sync
      always @(posedge clock_i) begin
        if (rst_i) begin
          sreg     <= 16'h0000;
          ofs      <= 1'b0;
          tx_left  <= 5'h00;
          rx_left  <= 5'h00;
          fs_cnt   <= 3'h0;
          pend     <= 1'b0;
          pend_reg <= 3'h0;
          pend_dat <= 8'h00;
          dac_hold <= 16'h0000;
        end else begin
          if (commit) begin
            // staged write consumed this tick
            pend <= 1'b0;
          end
          if (tick) begin
            ofs <= 1'b0;
            // frame sync precedes msb by one serial clock
            if (ofs) begin
              tx_left <= `CCSP_BIT_CNT; // R8
            end else if (tx_left != 5'h00) begin
              tx_left <= tx_left - 5'h01;
            end
            if (ch_ifs[i]) begin
              rx_left <= `CCSP_BIT_CNT;
            end else if (rx_left != 5'h00) begin
              rx_left <= rx_left - 5'h01;
            end
            // one register sends and receives at once
            if (tx_left != 5'h00 || rx_left != 5'h00) begin
              sreg <= word; // R8
            end
            // last bit of an incoming word
            if (rx_left == 5'h01) begin
              if ((!dmode || mmode) && is_ctrl(word)) begin
                if (is_mine(word)) begin
                  // hold until the next serial tick, when every staged write commits
                  if (word[`CCSP_WR_BIT]) begin
                    pend     <= 1'b1; // R13
                    pend_reg <= word[`CCSP_REG_HI:`CCSP_REG_LO];
                    pend_dat <= word[`CCSP_DATA_HI:`CCSP_DATA_LO];
                  end
                end else begin
                  // pass on with the address one lower
                  sreg <= {word[15], word[14:12] - 3'h1, word[11:0]}; // R12
                  ofs  <= 1'b1; // R12
                end
              end else if (dmode || mmode) begin
                // data words are claimed by frame sync count
                if (fs_cnt == casc) begin
                  dac_hold <= word; // R9 R18
                  fs_cnt   <= 3'h0; // R20
                end else begin
                  fs_cnt <= fs_cnt + 3'h1; // R17
                  ofs    <= 1'b1; // R19
                end
              end else begin
                // not ours in program mode: forward unchanged
                ofs <= 1'b1; // R11
              end
            end
            // sampling event: adc word in, both channels sync
            if (sample) begin
              sreg <= adc_flat[i*16 +: 16]; // R5
              ofs  <= 1'b1; // R10
            end
          end
        end
      end
    end
  endgenerate

endmodule

//--- inc/ccsp_consts.vh
// constants for the cascaded codec serial port
`ifndef CCSP_CONSTS_VH
`define CCSP_CONSTS_VH

// serial word layout
`define CCSP_WORD_W      16
`define CCSP_BIT_CNT     5'd16
`define CCSP_CTRL_BIT    15
`define CCSP_ADDR_HI     14
`define CCSP_ADDR_LO     12
`define CCSP_WR_BIT      11
`define CCSP_REG_HI      10
`define CCSP_REG_LO      8
`define CCSP_DATA_HI     7
`define CCSP_DATA_LO     0

// control register selects
`define CCSP_REG_CRA     3'h0
`define CCSP_REG_CRB     3'h1
`define CCSP_REG_CRC     3'h2
`define CCSP_REG_CRD     3'h3

// reset values
`define CCSP_CRA_RESET   8'h00
`define CCSP_CRB_RESET   8'h00
`define CCSP_CRC_RESET   8'h00
`define CCSP_CRD_RESET   8'h00

// first control register fields
`define CCSP_CRA_DATA    0
`define CCSP_CRA_MIXED   1
`define CCSP_CRA_CASC_HI 4
`define CCSP_CRA_CASC_LO 2

// second control register fields
`define CCSP_CRB_DIV_HI  7
`define CCSP_CRB_DIV_LO  6
`define CCSP_CRB_SCK_HI  5
`define CCSP_CRB_SCK_LO  4
`define CCSP_CRB_SR_HI   1
`define CCSP_CRB_SR_LO   0

// third control register fields
`define CCSP_CRC_ADC_PWR 0
`define CCSP_CRC_DAC_PWR 1
`define CCSP_CRC_REF_PWR 2

// fourth control register fields
`define CCSP_CRD_ADV_HI  2
`define CCSP_CRD_ADV_LO  0

// timing counts in divided clock cycles
`define CCSP_SAMPLE_BASE 12'h100
`define CCSP_ADV_STEP    12'h010

`endif

//--- hw/ccsp_clkgen.v
// divided clock, serial clock, sample and dac load strobes
`timescale 1ns/1ps
`include "ccsp_consts.vh"

module ccsp_clkgen (
  // clock and reset
  input  wire       clock_i,
  input  wire       rst_i,
  // rate settings
  input  wire [1:0] div_sel_i,
  input  wire [1:0] sclk_sel_i,
  input  wire [1:0] rate_sel_i,
  input  wire [2:0] adv_sel_i,
  // generated timing
  output reg        sclk_o,
  output wire       tick_o,
  output wire       sample_o,
  output wire       dac_load_o
);

  reg  [1:0]  dm_cnt;    // divided clock prescaler
  reg  [2:0]  half_cnt;  // serial clock half period count
  reg  [11:0] smp_cnt;   // divided clock cycles in sample period
  reg         armed;     // sample waits for next serial tick
  wire        dm_en;     // divided clock enable
  wire [2:0]  half_max;  // last count of a half period
  wire [11:0] smp_max;   // last count of a sample period
  wire [11:0] adv_cyc;   // dac advance in divided cycles

  assign dm_en    = (dm_cnt == div_sel_i);
  assign half_max = (3'h1 << sclk_sel_i) - 3'h1;
  assign smp_max  = (`CCSP_SAMPLE_BASE << rate_sel_i) - 12'h001;
  assign adv_cyc  = {9'h000, adv_sel_i} * `CCSP_ADV_STEP;

  // tick marks the rising serial clock edge
  // same test as the toggle, so a rate change never drops a tick
  assign tick_o     = dm_en & (half_cnt >= half_max) & ~sclk_o;
  assign sample_o   = tick_o & armed;
  // default load just before the sample, earlier by the advance
  assign dac_load_o = dm_en & (smp_cnt == smp_max - adv_cyc); // R6 R7

  // counters run from the master clock
  always @(posedge clock_i) begin
    if (rst_i) begin
      dm_cnt   <= 2'h0;
      half_cnt <= 3'h0;
      smp_cnt  <= 12'h000;
      sclk_o   <= 1'b0;
      armed    <= 1'b0;
    end else begin
      dm_cnt <= dm_en ? 2'h0 : dm_cnt + 2'h1;
      if (dm_en) begin
        // serial clock toggles each half period
        if (half_cnt >= half_max) begin
          half_cnt <= 3'h0;
          sclk_o   <= ~sclk_o;
        end else begin
          half_cnt <= half_cnt + 3'h1;
        end
        // sample period wrap arms the frame
        if (smp_cnt >= smp_max) begin
          smp_cnt <= 12'h000;
        end else begin
          smp_cnt <= smp_cnt + 12'h001;
        end
      end
      if (sample_o) begin
        armed <= 1'b0;
      end
      if (dm_en && smp_cnt >= smp_max) begin
        armed <= 1'b1;
      end
    end
  end

endmodule

//--- tb/ccsp_top_monitor.sv
// assertion checker on the pins of the cascaded codec serial port
`timescale 1ns/1ps
module ccsp_top_monitor (
  // clock and reset
  input wire        clock_i,
  input wire        rst_i,
  // serial link
  input wire        serial_data_out_o,
  input wire        output_frame_sync_o,
  input wire        sclk_o,
  // converter and status
  input wire [15:0] dac_ch1_o,
  input wire [15:0] dac_ch2_o,
  input wire [1:0]  data_mode_o,
  input wire [1:0]  mixed_mode_o,
  input wire [1:0]  adc_pwr_o,
  input wire [1:0]  dac_pwr_o,
  input wire [5:0]  casc_len_o
);
  // every check runs on the master clock and sleeps in reset
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a_reset_state_clear: assert property ($fell(rst_i) |-> casc_len_o == 6'h00 && data_mode_o == 2'h0)
    else $error("control state not clear after reset");
  a_fs_on_tick: assert property ($changed(output_frame_sync_o) |-> $rose(sclk_o))
    else $error("frame sync moved off a serial tick");
  a_sdo_on_tick: assert property ($changed(serial_data_out_o) |-> $rose(sclk_o))
    else $error("serial data moved off a serial tick");
  a_mode_pair: assert property ($rose(data_mode_o[0]) |-> $rose(data_mode_o[1]))
    else $error("data mode entered by one channel only");
  a_casc_pair: assert property ($changed(casc_len_o[2:0]) |-> $changed(casc_len_o[5:3]))
    else $error("cascade length applied apart");
  a_pwr_pair: assert property ($changed({adc_pwr_o[0], dac_pwr_o[0]}) |-> $changed({adc_pwr_o[1], dac_pwr_o[1]}))
    else $error("power controls applied apart");
  a_dac_pair: assert property ($changed(dac_ch1_o) |-> $changed(dac_ch2_o))
    else $error("dac outputs loaded apart");
  a_dac_before_fs: assert property ($changed(dac_ch1_o) |-> ##[1:40] $rose(output_frame_sync_o))
    else $error("dac load not just before frame sync");
  a_dac_in_data: assert property ($changed(dac_ch1_o) |-> data_mode_o[0] || mixed_mode_o[0])
    else $error("dac loaded in program mode");

  // main scenarios reached
  c_data_mode: cover property ($rose(data_mode_o[0]));
  c_dac_load: cover property ($changed(dac_ch2_o));
  c_frame: cover property ($rose(output_frame_sync_o));
endmodule

bind ccsp_top ccsp_top_monitor u_mon (.clock_i(clock_i), .rst_i(rst_i), .serial_data_out_o(serial_data_out_o),
  .output_frame_sync_o(output_frame_sync_o), .sclk_o(sclk_o), .dac_ch1_o(dac_ch1_o), .dac_ch2_o(dac_ch2_o),
  .data_mode_o(data_mode_o), .mixed_mode_o(mixed_mode_o), .adc_pwr_o(adc_pwr_o), .dac_pwr_o(dac_pwr_o),
  .casc_len_o(casc_len_o));

//--- tb/ccsp_host_model.sv
// behavioural host serial port facing the codec cascade
`timescale 1ns/1ps
module ccsp_host_model (
  // clock
  input wire  clock_i,
  // link from the codec
  input wire  serial_data_out_o,
  input wire  output_frame_sync_o,
  input wire  sclk_o,
  // link into the codec
  output reg  serial_data_in_i,
  output reg  input_frame_sync_i
);
  logic [15:0] txq[$];     // words queued for sending, in send order
  logic [15:0] rxq[$];     // words taken from the codec
  logic [15:0] txw;        // word on the wire
  logic [15:0] rxw;        // word being gathered
  logic        sclk_q = 0; // serial clock seen a cycle ago
  logic        busy = 0;   // frame in progress
  logic        tx_on = 0;  // this frame carries a word
  logic        d;          // next data level
  logic        f;          // next frame sync level
  int          cnt = 0;    // serial ticks since frame sync

  initial begin
    serial_data_in_i = 1'b0;
    input_frame_sync_i = 1'b0;
  end

  // one bit each way per serial tick, frames follow the codec's frame sync
  always @(negedge clock_i) begin
    if (sclk_o && !sclk_q) begin
      d = ~serial_data_in_i;  // an idle line keeps changing
      f = 1'b0;
      if (busy) begin
        cnt = cnt + 1;
        rxw = {rxw[14:0], serial_data_out_o};  // msb first
        if (tx_on) d = txw[16-cnt];
        if (cnt == 16) begin
          busy = 0;
          rxq.push_back(rxw);
        end
      end
      // next word leaves with no gap on the codec's frame sync
      if (!busy && output_frame_sync_o) begin
        busy = 1;
        cnt = 0;
        tx_on = (txq.size() > 0);
        if (tx_on) begin
          txw = txq.pop_front();
          f = 1'b1;
        end
      end
      // each pin is written once per serial tick
      serial_data_in_i = d;
      input_frame_sync_i = f;
    end
    sclk_q = sclk_o;
  end
endmodule

//--- tb/tb_ccsp_top.sv
// self-checking bench for the cascaded codec serial port
`timescale 1ns/1ps
`include "ccsp_consts.vh"
module tb_ccsp_top;
  logic        clock_i;         // master clock
  logic        rst_i;           // synchronous reset
  logic [15:0] adc_ch1_i;       // converter result, channel 1
  logic [15:0] adc_ch2_i;       // converter result, channel 2
  wire         serial_data_in_i;
  wire         input_frame_sync_i;
  wire         serial_data_out_o;
  wire         output_frame_sync_o;
  wire         sclk_o;
  wire  [15:0] dac_ch1_o;
  wire  [15:0] dac_ch2_o;
  wire  [1:0]  data_mode_o;
  wire  [1:0]  mixed_mode_o;
  wire  [1:0]  adc_pwr_o;
  wire  [1:0]  dac_pwr_o;
  wire  [1:0]  ref_pwr_o;
  wire  [5:0]  casc_len_o;
  wire  [1:0]  divided_master_clock_div_o;
  int          err_count = 0;   // mismatches
  int          num_checks = 0;  // comparisons made

  ccsp_top DUT (.clock_i(clock_i), .rst_i(rst_i), .serial_data_in_i(serial_data_in_i),
    .input_frame_sync_i(input_frame_sync_i), .serial_data_out_o(serial_data_out_o),
    .output_frame_sync_o(output_frame_sync_o), .sclk_o(sclk_o), .adc_ch1_i(adc_ch1_i), .dac_ch1_o(dac_ch1_o),
    .adc_ch2_i(adc_ch2_i), .dac_ch2_o(dac_ch2_o), .data_mode_o(data_mode_o), .mixed_mode_o(mixed_mode_o),
    .adc_pwr_o(adc_pwr_o), .dac_pwr_o(dac_pwr_o), .ref_pwr_o(ref_pwr_o), .casc_len_o(casc_len_o),
    .divided_master_clock_div_o(divided_master_clock_div_o));

  ccsp_host_model host (.clock_i(clock_i), .serial_data_out_o(serial_data_out_o),
    .output_frame_sync_o(output_frame_sync_o), .sclk_o(sclk_o), .serial_data_in_i(serial_data_in_i),
    .input_frame_sync_i(input_frame_sync_i));

  // one comparison of a 16-bit result
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // verdict and end of run
  task automatic results;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // control word: flag, address, write, register select, data
  function automatic logic [15:0] cw(input logic [2:0] a, input logic [2:0] r, input logic [7:0] v);
    return {1'b1, a, 1'b1, r, v};
  endfunction

  // wait for the idle tail of a sample period
  task automatic wait_quiet;
    int q;
    q = 0;
    for (int i = 0; i < 3000 && q < 90; i++) begin
      @(negedge clock_i);
      q = output_frame_sync_o ? 0 : q + 1;
    end
    if (q < 90) check(16'(q), 16'd90);
  endtask

  // queue one word per channel, channel 2 first, and let both leave
  task automatic push_pair(input logic [15:0] w2, input logic [15:0] w1);
    host.rxq.delete();
    host.txq.push_back(w2);
    host.txq.push_back(w1);
    for (int i = 0; i < 2000 && host.txq.size() > 0; i++) @(negedge clock_i);
    wait_quiet();
  endtask

  // one word per channel in one sample period, started from an idle tail
  task automatic send_pair(input logic [15:0] w2, input logic [15:0] w1);
    wait_quiet();
    push_pair(w2, w1);
  endtask

  // serial clock period in master clocks
  task automatic sclk_period(output logic [15:0] p);
    realtime t;
    @(posedge sclk_o);
    t = $realtime;
    @(posedge sclk_o);
    p = 16'(int'(($realtime - t) / 40.0));
  endtask

  // dac pair in data mode, adc words read back in the same period
  task automatic dac_pair(input logic [15:0] d2, input logic [15:0] d1);
    logic [15:0] old;
    old = dac_ch1_o;
    // queued at once: data mode wants two words every sample period
    push_pair(d2, d1);
    for (int i = 0; i < 600 && dac_ch1_o === old; i++) @(negedge clock_i);
    check(dac_ch2_o, d2);
    check(dac_ch1_o, d1);
    check(16'(host.rxq.size()), 16'h0002);
    check(host.rxq[0], adc_ch2_i);
    check(host.rxq[1], adc_ch1_i);
  endtask

  task automatic t_reset;
    check({casc_len_o, data_mode_o, mixed_mode_o, adc_pwr_o, dac_pwr_o, ref_pwr_o}, 16'h0000);
  endtask

  task automatic t_power;
    send_pair(cw(3'h1, `CCSP_REG_CRC, 8'h01), cw(3'h0, `CCSP_REG_CRC, 8'h06));
    check({10'h000, adc_pwr_o, dac_pwr_o, ref_pwr_o}, 16'h0025);
  endtask

  task automatic t_rates;
    logic [15:0] p;
    sclk_period(p);
    check(p, 16'h0002);
    send_pair(cw(3'h1, `CCSP_REG_CRB, 8'h10), cw(3'h0, `CCSP_REG_CRB, 8'h10));
    sclk_period(p);
    check(p, 16'h0004);
    check({14'h0000, divided_master_clock_div_o}, 16'h0000);
  endtask

  task automatic t_data;
    send_pair(cw(3'h1, `CCSP_REG_CRA, 8'h05), cw(3'h0, `CCSP_REG_CRA, 8'h05));
    check({casc_len_o, 8'h00, data_mode_o}, 16'h2403);
    dac_pair(16'h3c5a, 16'ha5c3);
    dac_pair(16'h1234, 16'h8765);
  endtask

  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  // watchdog
  initial begin
    #(40 * 30000);
    err_count++;
    results();
  end

  initial begin
    rst_i = 1'b1;
    adc_ch1_i = 16'h1357;
    adc_ch2_i = 16'h2468;
    repeat (2) @(negedge clock_i);
    rst_i = 1'b0;
    t_reset();
    t_power();
    t_rates();
    t_data();
    results();
  end
endmodule
